// ==== hw/srx_exec.sv ====
`timescale 1ns/1ps
module srx_exec
  import srx_pkg::*;
(
  input  wire logic        MCLK_I,
  input  wire logic        NRST_I,
  input  wire logic        CE_I,
  input  wire logic        HSEL_I,
  input  wire logic [31:0] HADDR_I,
  input  wire logic [1:0]  HTRANS_I,
  input  wire logic        HWRITE_I,
  input  wire logic [2:0]  HSIZE_I,
  input  wire logic [31:0] HWDATA_I,
  input  wire logic        HREADY_I,
  output logic [31:0]      HRDATA_O,
  output logic             HREADYOUT_O,
  output logic             HRESP_O
);
  function automatic logic [11:0] file_addr(input logic a, input logic [7:0] f,
                                             input logic [3:0] bank);
    if (a) file_addr = {bank, f};
    else file_addr = {(f < SRX_ACC_SPLIT) ? 4'h0 : SRX_ACC_HI_BANK, f};
  endfunction

  function automatic logic [5:0] file_idx(input logic [11:0] fa);
    file_idx = {fa[11], fa[4:0]};
  endfunction

  logic [7:0]  file_q [SRX_FILE_WORDS];
  logic [7:0]  file_d [SRX_FILE_WORDS];
  logic [7:0]  w_q, w_d, st_q, st_d, bank_q, bank_d;
  logic [7:0]  wsh_q, wsh_d, stsh_q, stsh_d, bsh_q, bsh_d;
  logic [7:0]  latu_q, latu_d, lath_q, lath_d;
  logic [20:0] pc_q, pc_d;
  logic [15:0] instr_q, instr_d;
  logic [11:0] fa_q, fa_d;
  srx_state_t  state_q, state_d;
  logic        wr_ph_q, wr_ph_d;
  logic [7:0]  adr_q, adr_d;
  logic [31:0] rdata_q, rdata_d;
  logic        push, pop;
  logic [20:0] stk_top;
  logic [4:0]  depth;
  logic        is_ret, is_rlc;
  logic [11:0] fa_now;
  logic [7:0]  fval, rot;

  srx_stack u_stack (
    .clk_i      (MCLK_I),
    .nrst_i     (NRST_I),
    .ce_i       (CE_I),
    .push_i     (push),
    .push_data_i(HWDATA_I[20:0]),
    .pop_i      (pop),
    .top_o      (stk_top),
    .depth_o    (depth)
  );

  assign is_ret = instr_q[15:1] == SRX_OP_RET_HI;
  assign is_rlc = instr_q[15:10] == SRX_OP_RLC_HI;
  assign fa_now = file_addr(instr_q[8], instr_q[7:0], bank_q[3:0]);
  assign fval   = file_q[file_idx(fa_now)];
  assign rot    = {fval[6:0], st_q[SRX_C_BIT]};
  assign pop    = CE_I && state_q == SRX_IDLE && wr_ph_q && adr_q == SRX_A_CTRL
                  && HWDATA_I[0] && is_ret;
  assign push   = CE_I && wr_ph_q && adr_q == SRX_A_STK_TOP;
  assign HREADYOUT_O = 1'b1;
  assign HRESP_O     = 1'b0;
  assign HRDATA_O    = rdata_q;

  always_comb begin
    file_d = file_q;
    {w_d, st_d, bank_d, wsh_d, stsh_d, bsh_d} = {w_q, st_q, bank_q, wsh_q, stsh_q, bsh_q};
    {latu_d, lath_d, pc_d, instr_d, fa_d} = {latu_q, lath_q, pc_q, instr_q, fa_q};
    state_d = state_q;
    wr_ph_d = HSEL_I && HREADY_I && HTRANS_I[1] && HWRITE_I;
    adr_d   = (HSEL_I && HREADY_I && HTRANS_I[1]) ? HADDR_I[7:0] : adr_q;
    rdata_d = rdata_q;
    case (state_q)
      SRX_RET2: state_d = SRX_DONE;
      SRX_DONE: state_d = SRX_IDLE;
      default:  state_d = SRX_IDLE;
    endcase
    if (wr_ph_q) begin
      case (adr_q)
        SRX_A_CTRL: begin
          if (HWDATA_I[0] && state_q == SRX_IDLE) begin
            if (is_ret) begin
              pc_d    = stk_top;
              state_d = SRX_RET2;
              if (instr_q[0]) begin
                w_d   = wsh_q;
                st_d  = stsh_q;
                bank_d = bsh_q;
              end
            end else if (is_rlc) begin
              fa_d = fa_now;
              st_d[SRX_C_BIT] = fval[7];
              st_d[SRX_N_BIT] = rot[7];
              st_d[SRX_Z_BIT] = rot == 8'h00;
              if (instr_q[9]) file_d[file_idx(fa_now)] = rot;
              else w_d = rot;
            end
          end
        end
        SRX_A_INSTR:  instr_d = HWDATA_I[15:0];
        SRX_A_WREG:   w_d = HWDATA_I[7:0];
        SRX_A_STATUS: st_d = HWDATA_I[7:0];
        SRX_A_BANK:     bank_d = HWDATA_I[7:0];
        SRX_A_WSH:      wsh_d = HWDATA_I[7:0];
        SRX_A_STSH:     stsh_d = HWDATA_I[7:0];
        SRX_A_BANK_SH:  bsh_d = HWDATA_I[7:0];
        SRX_A_PC:       pc_d = HWDATA_I[20:0];
        SRX_A_PC_UPLAT: latu_d = HWDATA_I[7:0];
        SRX_A_PC_HILAT: lath_d = HWDATA_I[7:0];
        SRX_A_FADDR:  fa_d = HWDATA_I[11:0];
        SRX_A_FDATA:  file_d[file_idx(fa_q)] = HWDATA_I[7:0];
        default: ;
      endcase
    end
    if (HSEL_I && HREADY_I && HTRANS_I[1] && !HWRITE_I) begin
      case (HADDR_I[7:0])
        SRX_A_CTRL:   rdata_d = {31'h0, state_d != SRX_IDLE};
        SRX_A_INSTR:  rdata_d = {16'h0, instr_d};
        SRX_A_WREG:   rdata_d = {24'h0, w_d};
        SRX_A_STATUS: rdata_d = {24'h0, st_d};
        SRX_A_BANK:     rdata_d = {24'h0, bank_d};
        SRX_A_WSH:      rdata_d = {24'h0, wsh_d};
        SRX_A_STSH:     rdata_d = {24'h0, stsh_d};
        SRX_A_BANK_SH:  rdata_d = {24'h0, bsh_d};
        SRX_A_PC:       rdata_d = {11'h0, pc_d};
        SRX_A_STK_TOP:  rdata_d = {6'h0, depth, stk_top};
        SRX_A_PC_UPLAT: rdata_d = {24'h0, latu_d};
        SRX_A_PC_HILAT: rdata_d = {24'h0, lath_d};
        SRX_A_FADDR:  rdata_d = {20'h0, fa_d};
        SRX_A_FDATA:  rdata_d = {24'h0, file_d[file_idx(fa_d)]};
        default:      rdata_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge MCLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      for (int i = 0; i < SRX_FILE_WORDS; i++) file_q[i] <= SRX_REG_RST;
      {w_q, st_q, bank_q} <= {3{SRX_REG_RST}};
      {wsh_q, stsh_q, bsh_q} <= {3{SRX_REG_RST}};
      {latu_q, lath_q} <= {2{SRX_REG_RST}};
      pc_q    <= SRX_PC_RST;
      instr_q <= 16'h0000;
      fa_q    <= 12'h000;
      state_q <= SRX_IDLE;
      wr_ph_q <= 1'b0;
      adr_q   <= 8'h00;
      rdata_q <= 32'h0000_0000;
    end else if (CE_I) begin
      file_q  <= file_d;
      {w_q, st_q, bank_q} <= {w_d, st_d, bank_d};
      {wsh_q, stsh_q, bsh_q} <= {wsh_d, stsh_d, bsh_d};
      {latu_q, lath_q} <= {latu_d, lath_d};
      pc_q    <= pc_d;
      instr_q <= instr_d;
      fa_q    <= fa_d;
      state_q <= state_d;
      wr_ph_q <= wr_ph_d;
      adr_q   <= adr_d;
      rdata_q <= rdata_d;
    end
  end

  a_ret_two_cycle: assert property (@(posedge MCLK_I) disable iff (!NRST_I)
    CE_I && state_q == SRX_RET2 |=> state_q == SRX_DONE)
    else $error("return did not take its second cycle");
  a_ret_pc_load: assert property (@(posedge MCLK_I) disable iff (!NRST_I)
    pop |=> pc_q == $past(stk_top))
    else $error("pc not loaded from stack top");
  a_ret_latch_keep: assert property (@(posedge MCLK_I) disable iff (!NRST_I)
    pop |=> $stable(latu_q) && $stable(lath_q))
    else $error("pc latches changed by return");
  a_ret_shadow: assert property (@(posedge MCLK_I) disable iff (!NRST_I)
    pop && instr_q[0] |=> w_q == $past(wsh_q) && st_q == $past(stsh_q)
    && bank_q == $past(bsh_q))
    else $error("shadow restore missing");
  a_ret_noshadow: assert property (@(posedge MCLK_I) disable iff (!NRST_I)
    pop && !instr_q[0] |=> $stable(w_q) && $stable(st_q) && $stable(bank_q))
    else $error("registers changed on plain return");
  a_rlc_carry: assert property (@(posedge MCLK_I) disable iff (!NRST_I)
    CE_I && state_q == SRX_IDLE && wr_ph_q && adr_q == SRX_A_CTRL && HWDATA_I[0]
    && is_rlc |=> st_q[SRX_C_BIT] == $past(fval[7]))
    else $error("carry not taken from bit 7");
  a_rlc_to_w: assert property (@(posedge MCLK_I) disable iff (!NRST_I)
    CE_I && state_q == SRX_IDLE && wr_ph_q && adr_q == SRX_A_CTRL && HWDATA_I[0]
    && is_rlc && !instr_q[9] |=> w_q == $past(rot))
    else $error("rotate result not in W");
  a_rlc_zero: assert property (@(posedge MCLK_I) disable iff (!NRST_I)
    CE_I && state_q == SRX_IDLE && wr_ph_q && adr_q == SRX_A_CTRL && HWDATA_I[0]
    && is_rlc |=> st_q[SRX_Z_BIT] == ($past(rot) == 8'h00))
    else $error("zero flag wrong");
  a_access_bank: assert property (@(posedge MCLK_I) disable iff (!NRST_I)
    !instr_q[8] && instr_q[7] |-> fa_now[11:8] == SRX_ACC_HI_BANK)
    else $error("access bank not used");
  a_access_low: assert property (@(posedge MCLK_I) disable iff (!NRST_I)
    !instr_q[8] && !instr_q[7] |-> fa_now[11:8] == 4'h0)
    else $error("low access bank not used");
  a_rlc_bank_sel: assert property (@(posedge MCLK_I) disable iff (!NRST_I)
    instr_q[8] |-> fa_now[11:8] == bank_q[3:0])
    else $error("bank select not used");
  a_rlc_neg: assert property (@(posedge MCLK_I) disable iff (!NRST_I)
    CE_I && state_q == SRX_IDLE && wr_ph_q && adr_q == SRX_A_CTRL && HWDATA_I[0]
    && is_rlc |=> st_q[SRX_N_BIT] == $past(rot[7]))
    else $error("negative flag wrong");
  a_rlc_to_file: assert property (@(posedge MCLK_I) disable iff (!NRST_I)
    CE_I && state_q == SRX_IDLE && wr_ph_q && adr_q == SRX_A_CTRL && HWDATA_I[0]
    && is_rlc && instr_q[9] |=> file_q[file_idx(fa_q)] == $past(rot))
    else $error("rotate result not in file");
endmodule

// ==== hw/srx_pkg.sv ====
package srx_pkg;
  // Instruction encodings
  localparam logic [14:0] SRX_OP_RET_HI   = 15'h0009;  // 0000 0000 0001 001 (then s)
  localparam logic [5:0]  SRX_OP_RLC_HI   = 6'h0D;     // 0011 01 (then d, a)
  // Register map (AHB byte addresses)
  localparam logic [7:0]  SRX_A_CTRL      = 8'h00;  // W: bit0 go; R: bit0 busy
  localparam logic [7:0]  SRX_A_INSTR     = 8'h04;  // Instruction word
  localparam logic [7:0]  SRX_A_WREG      = 8'h08;
  localparam logic [7:0]  SRX_A_STATUS    = 8'h0C;  // bit0 C, bit2 Z, bit4 N
  localparam logic [7:0]  SRX_A_BANK      = 8'h10;
  localparam logic [7:0]  SRX_A_WSH       = 8'h14;
  localparam logic [7:0]  SRX_A_STSH      = 8'h18;
  localparam logic [7:0]  SRX_A_BANK_SH   = 8'h1C;
  localparam logic [7:0]  SRX_A_PC        = 8'h20;  // 21-bit program counter
  localparam logic [7:0]  SRX_A_STK_TOP   = 8'h24;  // R: stack top; W: push
  localparam logic [7:0]  SRX_A_PC_UPLAT  = 8'h28;
  localparam logic [7:0]  SRX_A_PC_HILAT  = 8'h2C;
  localparam logic [7:0]  SRX_A_FADDR     = 8'h30;  // R: last 12-bit file address
  localparam logic [7:0]  SRX_A_FDATA     = 8'h34;  // File window: index in FADDR
  // Status field positions
  localparam int          SRX_C_BIT       = 0;
  localparam int          SRX_Z_BIT       = 2;
  localparam int          SRX_N_BIT       = 4;
  // Access bank split and sizes
  localparam logic [7:0]  SRX_ACC_SPLIT   = 8'h80;
  localparam logic [3:0]  SRX_ACC_HI_BANK = 4'hF;
  localparam int          SRX_STK_DEPTH   = 31;
  localparam int          SRX_FILE_WORDS  = 64;
  localparam logic [20:0] SRX_PC_RST      = 21'h000000;
  localparam logic [7:0]  SRX_REG_RST     = 8'h00;
  typedef enum logic [1:0] {SRX_IDLE, SRX_RET2, SRX_DONE} srx_state_t;
endpackage

// ==== hw/srx_stack.sv ====
`timescale 1ns/1ps
module srx_stack
  import srx_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        nrst_i,
  input  wire logic        ce_i,
  input  wire logic        push_i,
  input  wire logic [20:0] push_data_i,
  input  wire logic        pop_i,
  output logic [20:0]      top_o,
  output logic [4:0]       depth_o
);
  logic [20:0] mem_q [SRX_STK_DEPTH];
  logic [20:0] mem_d [SRX_STK_DEPTH];
  logic [4:0]  ptr_q;
  logic [4:0]  ptr_d;

  always_comb begin
    mem_d = mem_q;
    ptr_d = ptr_q;
    if (push_i && ptr_q < 5'(SRX_STK_DEPTH)) begin
      mem_d[ptr_q] = push_data_i;
      ptr_d = ptr_q + 5'h01;
    end else if (pop_i && ptr_q != 5'h00) begin
      ptr_d = ptr_q - 5'h01;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ptr_q <= 5'h00;
      for (int i = 0; i < SRX_STK_DEPTH; i++) mem_q[i] <= SRX_PC_RST;
    end else if (ce_i) begin
      ptr_q <= ptr_d;
      mem_q <= mem_d;
    end
  end

  // Empty stack reads as zero
  assign top_o   = (ptr_q == 5'h00) ? SRX_PC_RST : mem_q[ptr_q - 5'h01];
  assign depth_o = ptr_q;
endmodule

// ==== testbench/tb_top.sv ====
`timescale 1ns/1ps
module tb_top
  import srx_pkg::*;
;
  logic        MCLK_I = 1'b0;
  logic        NRST_I = 1'b0;
  logic        CE_I = 1'b1;
  logic        HSEL_I = 1'b0;
  logic [31:0] HADDR_I = 32'h0;
  logic [1:0]  HTRANS_I = 2'h0;
  logic        HWRITE_I = 1'b0;
  logic [2:0]  HSIZE_I = 3'h2;
  logic [31:0] HWDATA_I = 32'h0;
  logic [31:0] HRDATA_O;
  logic        HREADYOUT_O;
  logic        HRESP_O;
  int          n_mismatch = 0;
  int          compares = 0;
  int          cyc = 0;

  srx_exec uut (.MCLK_I(MCLK_I), .NRST_I(NRST_I), .CE_I(CE_I), .HSEL_I(HSEL_I),
    .HADDR_I(HADDR_I), .HTRANS_I(HTRANS_I), .HWRITE_I(HWRITE_I), .HSIZE_I(HSIZE_I),
    .HWDATA_I(HWDATA_I), .HREADY_I(HREADYOUT_O), .HRDATA_O(HRDATA_O),
    .HREADYOUT_O(HREADYOUT_O), .HRESP_O(HRESP_O));

  always #5 MCLK_I = ~MCLK_I;

  task automatic stop_test();
    if (n_mismatch == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // Hang guard: the whole sequence needs well under a thousand cycles
  always @(posedge MCLK_I) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_mismatch = n_mismatch + 1;
      stop_test();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
    end
  endtask

  // One single transfer: address phase held until hready, then data phase
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge MCLK_I);
    HSEL_I   <= 1'b1;
    HTRANS_I <= 2'b10;
    HADDR_I  <= {24'h0, a};
    HWRITE_I <= wr;
    do @(posedge MCLK_I); while (HREADYOUT_O !== 1'b1);
    HTRANS_I <= 2'b00;
    HWDATA_I <= d;
    do @(posedge MCLK_I); while (HREADYOUT_O !== 1'b1);
    q = HRDATA_O;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    xfer(1'b0, a, 32'h0, q);
  endtask

  task automatic rot(input logic [11:0] ea, input logic [7:0] f, input logic d,
                     input logic a, input logic [7:0] v, input logic c,
                     input logic [3:0] bank);
    logic [7:0]  r;
    logic [31:0] x;
    r = {v[6:0], c};
    wr(SRX_A_FADDR, {20'h0, ea});
    wr(SRX_A_FDATA, {24'h0, v});
    // Park the window elsewhere so the rotate must set the address itself
    wr(SRX_A_FADDR, 32'h7FF);
    wr(SRX_A_STATUS, {31'h0, c});
    wr(SRX_A_WREG, 32'h5A);
    wr(SRX_A_BANK, {28'h0, bank});
    wr(SRX_A_INSTR, {16'h0, SRX_OP_RLC_HI, d, a, f});
    wr(SRX_A_CTRL, 32'h1);
    rd(SRX_A_CTRL, x);
    chk(x, 32'h0);
    rd(SRX_A_FADDR, x);
    chk(x, {20'h0, ea});
    rd(SRX_A_FDATA, x);
    chk(x, {24'h0, d ? r : v});
    rd(SRX_A_WREG, x);
    chk(x, {24'h0, d ? 8'h5A : r});
    rd(SRX_A_STATUS, x);
    chk(x, {27'h0, r[7], 1'b0, r == 8'h00, 1'b0, v[7]});
  endtask

  task automatic ret(input logic s, input logic [20:0] pc, input logic [4:0] dep,
                     input logic [7:0] w, input logic [7:0] st, input logic [7:0] bk);
    logic [31:0] x;
    wr(SRX_A_INSTR, {16'h0, SRX_OP_RET_HI, s});
    wr(SRX_A_CTRL, 32'h1);
    // Busy spans only the return's own cycles, so it has cleared by the first read
    rd(SRX_A_CTRL, x);
    chk(x, 32'h0);
    repeat (8) begin
      rd(SRX_A_CTRL, x);
      if (x[0] === 1'b0) break;
    end
    chk(x, 32'h0);
    rd(SRX_A_PC, x);
    chk(x, {11'h0, pc});
    rd(SRX_A_STK_TOP, x);
    chk({27'h0, x[25:21]}, {27'h0, dep});
    rd(SRX_A_WREG, x);
    chk(x, {24'h0, w});
    rd(SRX_A_STATUS, x);
    chk(x, {24'h0, st});
    rd(SRX_A_BANK, x);
    chk(x, {24'h0, bk});
    rd(SRX_A_PC_UPLAT, x);
    chk(x, 32'h05);
    rd(SRX_A_PC_HILAT, x);
    chk(x, 32'h6B);
  endtask

  initial begin
    logic [31:0] x;
    repeat (2) @(posedge MCLK_I);
    NRST_I <= 1'b1;
    rot(12'h005, 8'h05, 1'b1, 1'b0, 8'hE6, 1'b0, 4'h3);
    rot(12'h310, 8'h10, 1'b0, 1'b1, 8'h80, 1'b0, 4'h3);
    rot(12'hF90, 8'h90, 1'b1, 1'b0, 8'h01, 1'b1, 4'h3);
    rot(12'h2A1, 8'hA1, 1'b1, 1'b1, 8'h55, 1'b1, 4'h2);
    wr(SRX_A_STK_TOP, 32'h01234);
    wr(SRX_A_STK_TOP, 32'h0ABCD);
    rd(SRX_A_STK_TOP, x);
    chk(x, {6'h0, 5'h02, 21'h0ABCD});
    wr(SRX_A_WREG, 32'h11);
    wr(SRX_A_STATUS, 32'h01);
    wr(SRX_A_BANK, 32'h3);
    wr(SRX_A_WSH, 32'h22);
    wr(SRX_A_STSH, 32'h14);
    wr(SRX_A_BANK_SH, 32'h7);
    wr(SRX_A_PC_UPLAT, 32'h05);
    wr(SRX_A_PC_HILAT, 32'h6B);
    ret(1'b0, 21'h0ABCD, 5'h01, 8'h11, 8'h01, 8'h03);
    ret(1'b1, 21'h01234, 5'h00, 8'h22, 8'h14, 8'h07);
    // Unmapped offset reads back as zero, and the response stays OKAY
    rd(8'h3C, x);
    chk(x, 32'h0);
    chk({31'h0, HRESP_O}, 32'h0);
    // A write made while the clock enable is low must be lost
    @(posedge MCLK_I);
    CE_I <= 1'b0;
    wr(SRX_A_WREG, 32'h99);
    @(posedge MCLK_I);
    CE_I <= 1'b1;
    rd(SRX_A_WREG, x);
    chk(x, 32'h22);
    stop_test();
  end
endmodule
